// ===== shared/bopa_pkg.sv
// Constants shared by the bus-written output port array.
// Assumes an APB master on a 16-bit short I/O address space.
package bopa_pkg;

  // Bus geometry
  localparam int BOPA_ADDR_W = 16;
  localparam int BOPA_DATA_W = 32;
  localparam int BOPA_PORTS = 8;
  localparam int BOPA_PORT_W = 8;
  localparam int BOPA_OUT_W = 64;

  // Port window: two words, four ports in each
  localparam int BOPA_WIN_LSB = 3;
  localparam logic [2:0] BOPA_PORT_LO_OFF = 3'h0;
  localparam logic [2:0] BOPA_PORT_HI_OFF = 3'h4;

  // Control and status window: one word
  localparam int BOPA_CSR_LSB = 2;

  // Control and status register fields
  localparam int BOPA_TEST_BIT = 0;
  localparam int BOPA_FAIL_BIT = 1;
  localparam int BOPA_POL_BIT = 2;
  localparam int BOPA_AM_BIT = 3;

  // Reset values
  localparam logic BOPA_TEST_RST = 1'b0;
  localparam logic BOPA_FAIL_RST = 1'b1;
  localparam logic [7:0] BOPA_PORT_RST = 8'h00;
  localparam logic [31:0] BOPA_RDATA_RST = 32'h0000_0000;

  // Legal byte-lane patterns: byte, aligned half word, word
  localparam logic [3:0] BOPA_STRB_B0 = 4'h1;
  localparam logic [3:0] BOPA_STRB_B1 = 4'h2;
  localparam logic [3:0] BOPA_STRB_B2 = 4'h4;
  localparam logic [3:0] BOPA_STRB_B3 = 4'h8;
  localparam logic [3:0] BOPA_STRB_H0 = 4'h3;
  localparam logic [3:0] BOPA_STRB_H1 = 4'hc;
  localparam logic [3:0] BOPA_STRB_W = 4'hf;

  // Strap synchroniser depth
  localparam int BOPA_SYNC_N = 3;

endpackage : bopa_pkg

// ===== src/bopa_top.sv
// Bus-written output port array: eight byte-wide output latches and a
// separately decoded control and status register, reached over APB.
// Assumes straps (jumpers) are static pins from outside the pclk domain
// and that the half-bridge drivers take a source and a sink enable each.
//
// How it works
// - Eight byte-wide output latches give sixty-four latched output bits.
// - Each port addressable; byte, half-word and word transfers on natural alignment.
// - A strap picks supervisory or nonprivileged access; supervisory by default.
// - Control and status register has its own comparator and base strap.
// - With test mode set, all sixty-four outputs are forced off.
// - Fail indicator lit from reset until software clears it.
// - A strap per byte picks source-only or source/sink drive.
// - Positive true, source-only: zero gives high impedance, one sources.
// - Negative true, source-only: zero sources, one gives high impedance.
// - Positive true, source/sink: zero sinks, one sources.
// - Negative true, source/sink: zero sources, one sinks.
`timescale 1ns/1ps
`default_nettype none

module bopa_top #(
  parameter int PORTS = bopa_pkg::BOPA_PORTS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bopa_pkg::BOPA_ADDR_W-1:0] paddr,
  input wire logic [bopa_pkg::BOPA_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [bopa_pkg::BOPA_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic am_nonpriv_strap,
  input wire logic neg_true_strap,
  input wire logic [PORTS-1:0] sink_en_strap,
  input wire logic [bopa_pkg::BOPA_ADDR_W-1:bopa_pkg::BOPA_WIN_LSB] port_base_strap,
  input wire logic [bopa_pkg::BOPA_ADDR_W-1:bopa_pkg::BOPA_CSR_LSB] csr_base_strap,
  output logic [PORTS*8-1:0] out_source,
  output logic [PORTS*8-1:0] out_sink,
  output logic fail_led
);
  import bopa_pkg::*;

  localparam int PB_W = BOPA_ADDR_W - BOPA_WIN_LSB;
  localparam int CB_W = BOPA_ADDR_W - BOPA_CSR_LSB;
  localparam int STRAP_W = 2 + PORTS + PB_W + CB_W;

  // Strap bundle, synchroniser stages and the agreed value
  logic [STRAP_W-1:0] strap_in;
  logic [STRAP_W-1:0] sync1_r;
  logic [STRAP_W-1:0] sync2_r;
  logic [STRAP_W-1:0] sync3_r;
  logic [STRAP_W-1:0] strap_r;

  logic nonpriv_cfg;
  logic neg_true_cfg;
  logic [PORTS-1:0] sink_cfg;
  logic [PB_W-1:0] port_base_cfg;
  logic [CB_W-1:0] csr_base_cfg;

  // Latches and control state
  logic [7:0] port_r [PORTS];
  logic test_r;
  logic fail_r;
  logic ack_r;
  logic [BOPA_DATA_W-1:0] rdata_r;
  logic err_r;

  // Decode terms
  logic acc_phase;
  logic am_ok;
  logic hit_csr;
  logic hit_port;
  logic hi_word;
  logic strb_ok;
  logic sel_ok;
  logic wr_commit;
  logic [BOPA_DATA_W-1:0] rd_word;
  logic port_off_ok;
  logic csr_wr;
  logic port_wr;

  // Flattened latches and per-bit next enables
  logic [PORTS*8-1:0] lat_bits;
  logic [PORTS*8-1:0] snk_mask;
  logic [PORTS*8-1:0] out_source_nxt;
  logic [PORTS*8-1:0] out_sink_nxt;

  // Lane pattern must be a byte, an aligned half word or a full word
  function automatic logic strb_legal(input logic [3:0] s);
    logic r;
    r = 1'b0;
    if (s == BOPA_STRB_B0 || s == BOPA_STRB_B1) begin
      r = 1'b1;
    end else if (s == BOPA_STRB_B2 || s == BOPA_STRB_B3) begin
      r = 1'b1;
    end else if (s == BOPA_STRB_H0 || s == BOPA_STRB_H1) begin
      r = 1'b1;
    end else if (s == BOPA_STRB_W) begin
      r = 1'b1;
    end
    return r;
  endfunction : strb_legal

  // Source enable for one bit: active level after polarity, gated by test
  function automatic logic drv_src(input logic d, input logic neg, input logic tst);
    return ~tst & (d ^ neg);
  endfunction : drv_src

  // Sink enable: only in source/sink mode, when the bit is inactive
  function automatic logic drv_snk(input logic d, input logic neg,
                                   input logic snk, input logic tst);
    return ~tst & snk & ~(d ^ neg);
  endfunction : drv_snk

  // Byte lane that carries port p inside the window word holding it
  function automatic logic port_lane_en(input logic hi, input logic [3:0] s, input int p);
    return (hi == (p >= 4)) && s[p % 4];
  endfunction : port_lane_en

  // Control word as software reads it; bits above the fields read zero
  function automatic logic [BOPA_DATA_W-1:0] csr_word(input logic tst,
                                                       input logic fl,
                                                       input logic pol,
                                                       input logic amc);
    logic [BOPA_DATA_W-1:0] w;
    w = BOPA_RDATA_RST;
    w[BOPA_TEST_BIT] = tst;
    w[BOPA_FAIL_BIT] = fl;
    w[BOPA_POL_BIT] = pol;
    w[BOPA_AM_BIT] = amc;
    return w;
  endfunction : csr_word

  assign strap_in = {am_nonpriv_strap, neg_true_strap, sink_en_strap,
                     port_base_strap, csr_base_strap};

  // Straps are jumpers: they move only by hand, so they are slow but not
  // clocked. Three stages keep a half-settled pin away from decode, at
  // the price of a few edges before a moved jumper takes effect.
  // Three-stage capture of the straps; jumpers are not on pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= strap_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A strap bit takes effect once stages two and three agree.
  // A bit that still differs keeps its old agreed value, so decode
  // never sees a one-cycle glimpse of a bouncing jumper.
  genvar gi;
  generate
    for (gi = 0; gi < STRAP_W; gi++) begin : g_agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          strap_r[gi] <= 1'b0;
        end else if (sync2_r[gi] == sync3_r[gi]) begin
          strap_r[gi] <= sync3_r[gi];
        end
      end
    end
  endgenerate

  // Unpack the agreed straps; reset value zero means supervisory access
  assign csr_base_cfg = strap_r[CB_W-1:0];
  assign port_base_cfg = strap_r[CB_W+PB_W-1:CB_W];
  assign sink_cfg = strap_r[CB_W+PB_W+PORTS-1:CB_W+PB_W];
  assign neg_true_cfg = strap_r[STRAP_W-2];
  assign nonpriv_cfg = strap_r[STRAP_W-1];

  // Address map seen from the bus:
  //   port window  - eight bytes at port_base_strap, offset in paddr[2:0]
  //   word at +0   - lanes 0 to 3 carry ports 0 to 3
  //   word at +4   - lanes 0 to 3 carry ports 4 to 7
  //   control word - one word at csr_base_strap
  // The two comparators share nothing, so the control word may sit away
  // from the ports, next to the control words of other boards.
  // Other offsets in the window, or a write lane shape that is not a byte, an
  // aligned half word or a word, get pslverr and touch no latch.
  // Reset straps are all zero, so both windows sit at address zero then.

  // Access phase of a transfer, high through its wait cycle and its answer cycle
  assign acc_phase = psel & penable;

  // Address modifier check: pprot[0] high marks a privileged access.
  // A refused access is still answered, so the master never hangs here.
  assign am_ok = nonpriv_cfg ? ~pprot[0] : pprot[0];

  // Two independent comparators; the control register wins a collision
  assign hit_csr = am_ok && (paddr[BOPA_ADDR_W-1:BOPA_CSR_LSB] == csr_base_cfg);
  assign hit_port = am_ok && !hit_csr &&
                    (paddr[BOPA_ADDR_W-1:BOPA_WIN_LSB] == port_base_cfg);
  assign hi_word = (paddr[2:0] == BOPA_PORT_HI_OFF);
  assign port_off_ok = (paddr[2:0] == BOPA_PORT_LO_OFF) || hi_word;

  // Reads use every lane, so only writes are checked for lane shape.
  // Software picks its bytes out of the returned word.
  assign strb_ok = !pwrite || strb_legal(pstrb);

  // Port window words sit on offsets 0 and 4 only
  always_comb begin
    sel_ok = 1'b0;
    if (hit_csr) begin
      sel_ok = strb_ok;
    end else if (hit_port && port_off_ok) begin
      sel_ok = strb_ok;
    end
  end

  // A write lands at the edge where pready is seen high
  assign wr_commit = acc_phase & ack_r & pwrite & sel_ok;

  // Commit split by target, so each register group sees one plain enable
  assign csr_wr = wr_commit & hit_csr & pstrb[0];
  assign port_wr = wr_commit & hit_port;

  // Transfer timing, one cycle a line:
  //   setup  - psel high, penable low, ack_r low
  //   access - penable high; answer and error latched at its end
  //   answer - ack_r high, so pready; a write lands at this edge
  // ack_r falls by itself after one cycle, so a setup that follows at
  // once is never taken for a second access.
  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc_phase & ~ack_r;
    end
  end

  assign pready = ack_r;

  // Read word assembled from the decoded register
  always_comb begin
    rd_word = BOPA_RDATA_RST;
    if (hit_csr) begin
      rd_word = csr_word(test_r, fail_r, neg_true_cfg, nonpriv_cfg);
    end else if (hit_port && hi_word) begin
      rd_word = {port_r[7], port_r[6], port_r[5], port_r[4]};
    end else if (hit_port) begin
      rd_word = {port_r[3], port_r[2], port_r[1], port_r[0]};
    end
  end

  // Answer latched in the wait cycle; unmapped or bad lanes give an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= BOPA_RDATA_RST;
      err_r <= 1'b0;
    end else if (acc_phase && !ack_r) begin
      rdata_r <= (sel_ok && !pwrite) ? rd_word : BOPA_RDATA_RST;
      err_r <= ~sel_ok;
    end
  end

  assign prdata = rdata_r;
  assign pslverr = ack_r & err_r;

  // Output latches, one byte lane each; half-words and words hit several.
  // A refused write never gets here, since sel_ok gates the commit.
  generate
    for (gi = 0; gi < PORTS; gi++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_r[gi] <= BOPA_PORT_RST;
        end else if (port_wr && port_lane_en(hi_word, pstrb, gi)) begin
          port_r[gi] <= pwdata[(gi % 4)*8 +: 8];
        end
      end
    end
  endgenerate

  // Test mode bit follows each control register write that carries byte lane 0.
  // Latches are left alone, so leaving test restores the last outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_r <= BOPA_TEST_RST;
    end else if (csr_wr) begin
      test_r <= pwdata[BOPA_TEST_BIT];
    end
  end

  // Fail indicator: lit from reset, cleared by writing a one, never relit.
  // Writing a zero leaves it alone, so a routine that only touches the
  // test bit cannot light the lamp again; only reset does that.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_r <= BOPA_FAIL_RST;
    end else if (csr_wr && pwdata[BOPA_FAIL_BIT]) begin
      fail_r <= 1'b0;
    end
  end

  assign fail_led = fail_r;

  // Latches flattened so bit i of the array is bit i%8 of port i/8
  generate
    for (gi = 0; gi < PORTS*8; gi++) begin : g_flat
      assign lat_bits[gi] = port_r[gi/8][gi%8];
      assign snk_mask[gi] = sink_cfg[gi/8];
    end
  endgenerate

  // Next enables bit by bit; the two functions take opposite senses,
  // so source and sink are never asked for at once
  generate
    for (gi = 0; gi < PORTS*8; gi++) begin : g_nxt
      assign out_source_nxt[gi] = drv_src(lat_bits[gi], neg_true_cfg,
                                          test_r);
      assign out_sink_nxt[gi] = drv_snk(lat_bits[gi], neg_true_cfg,
                                        snk_mask[gi], test_r);
    end
  endgenerate

  // Driver enables, registered so the pins see no decode glitches.
  // Off means neither source nor sink, i.e. high impedance.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_source <= '0;
      out_sink <= '0;
    end else begin
      out_source <= out_source_nxt;
      out_sink <= out_sink_nxt;
    end
  end

  // Limits: the read mux names ports 0 to 7 outright, so another PORTS
  // value needs it widened as well. Straps are taken as still while a
  // transfer is in flight; a jumper moved mid-transfer may be answered
  // with the old decode for a few edges.

endmodule : bopa_top

`default_nettype wire

// ===== sim/bopa_load.sv
// Load model standing on the driver side of the output array.
// Assumes source and sink enables per bit from the block.
`timescale 1ns/1ps
`default_nettype none
module bopa_load #(
  parameter int W = 64
) (
  input wire logic [W-1:0] src,
  input wire logic [W-1:0] snk,
  output var logic [W-1:0] lvl,
  output var logic [W-1:0] hiz
);
  // A floating pin is flagged apart on hiz; lvl shows it as zero, the same as a sinking pin
  assign lvl = src;
  assign hiz = ~src & ~snk;
endmodule : bopa_load
`default_nettype wire

// ===== sim/bopa_chk_assertions.sv
// Checker on the ports of the output port array.
// Assumes straps held steady for some edges before decode is judged.
`timescale 1ns/1ps
`default_nettype none
module bopa_chk import bopa_pkg::*; #(
  parameter int PORTS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic am_nonpriv_strap,
  input wire logic [PORTS-1:0] sink_en_strap,
  input wire logic [15:3] port_base_strap,
  input wire logic [15:2] csr_base_strap,
  input wire logic [PORTS*8-1:0] out_source,
  input wire logic [PORTS*8-1:0] out_sink,
  input wire logic fail_led
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic hit;
  logic csr_w;
  logic [PORTS*8-1:0] msk;
  // Decode seen from outside, from the raw strap pins
  assign acc = psel && penable && pready;
  assign hit = paddr[15:2] == csr_base_strap;
  assign csr_w = acc && pwrite && hit && pstrb[0] && !pslverr;
  always_comb for (int i = 0; i < PORTS*8; i++) msk[i] = sink_en_strap[i/8];
  property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("no single wait state");
  property p_err; pslverr |-> pready && prdata == 0; endproperty
  a_err: assert property (p_err) else $error("bad refusal");
  property p_prot; acc && pprot[0] == am_nonpriv_strap |-> pslverr; endproperty
  a_prot: assert property (p_prot) else $error("wrong modifier taken");
  property p_csr; acc && hit && pprot[0] != am_nonpriv_strap |-> !pslverr; endproperty
  a_csr: assert property (p_csr) else $error("control word refused");
  property p_test; csr_w && pwdata[0] |-> ##2 out_source == 0 && out_sink == 0; endproperty
  a_test: assert property (p_test) else $error("outputs on in test");
  property p_fkeep; !$past(fail_led) |-> !fail_led; endproperty
  a_fkeep: assert property (p_fkeep) else $error("indicator relit");
  property p_fclr; csr_w && pwdata[1] |-> ##[1:2] !fail_led; endproperty
  a_fclr: assert property (p_fclr) else $error("indicator kept");
  property p_short; (out_source & out_sink) == 0; endproperty
  a_short: assert property (p_short) else $error("source and sink both on");
  property p_sink; sink_en_strap == $past(sink_en_strap, 6) |-> (out_sink & ~msk) == 0;
  endproperty
  a_sink: assert property (p_sink) else $error("sink on a source-only byte");
  property p_align; acc && paddr[15:3] == port_base_strap && !hit && paddr[1:0] != 0
    |-> pslverr; endproperty
  a_align: assert property (p_align) else $error("unaligned port taken");
endmodule : bopa_chk
`default_nettype wire

// ===== sim/bopa_top_tb.sv
// Self-checking bench for the output port array, APB master inside.
// Assumes one wait state and straps settled six edges after a change.
`timescale 1ns/1ps
`default_nettype none
module bopa_top_tb;
  localparam logic [15:0] PB = 16'h0100;
  localparam logic [15:0] CB = 16'h0200;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 0;
  logic [2:0] pprot = 3'h1;
  logic am = 0;
  logic neg = 0;
  logic [7:0] sink = 0;
  logic [15:3] pbs = PB[15:3];
  logic [15:2] cbs = CB[15:2];
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, fail_led;
  logic [63:0] out_source, out_sink, lvl, hiz;
  int fails = 0;
  int comparisons = 0;
  bopa_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pprot, .prdata, .pready, .pslverr, .am_nonpriv_strap(am), .neg_true_strap(neg),
    .sink_en_strap(sink), .port_base_strap(pbs), .csr_base_strap(cbs), .out_source,
    .out_sink, .fail_led);
  bopa_load u_load (.src(out_source), .snk(out_sink), .lvl, .hiz);
  always #10 pclk = ~pclk;
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // One APB transfer; the answer is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic t_reset;
    chk("fail_led", fail_led, 1);
    chk("outputs", out_source | out_sink, 0);
    apb(0, CB, 0, 4'hf);
    chk("csr", rd, 32'h0000_0002);
    $display("t_reset done");
  endtask : t_reset
  // Both polarities over a mixed per-byte drive style
  task automatic t_map;
    logic [63:0] d, a, m;
    d = 64'ha5c3_0f3c_9612_ff00;
    for (int p = 0; p < 2; p++) begin
      neg <= p[0];
      sink <= 8'h5a;
      wt(6);
      apb(1, PB, d[31:0], 4'hf);
      apb(1, PB | 16'h0004, d[63:32], 4'hf);
      wt(2);
      a = d ^ {64{p[0]}};
      for (int i = 0; i < 64; i++) m[i] = sink[i/8];
      chk("lvl", lvl, a);
      chk("hiz", hiz, ~a & ~m);
      chk("sink", out_sink, ~a & m);
      apb(0, CB, 0, 4'hf);
      chk("csr pol", rd, p[0] ? 32'h0000_0006 : 32'h0000_0002);
    end
    neg <= 0;
    wt(6);
    $display("t_map done");
  endtask : t_map
  task automatic t_lanes;
    apb(1, PB | 16'h0004, 32'h0000_7700, 4'h2);
    chk("byte err", err, 0);
    apb(1, PB, 32'h1234_0000, 4'hc);
    apb(1, PB | 16'h0001, 32'hffff_ffff, 4'hf);
    chk("offset err", err, 1);
    apb(1, PB, 32'hffff_ffff, 4'h5);
    chk("lane err", err, 1);
    apb(0, 16'h0300, 0, 4'hf);
    chk("unmapped", {err, rd}, 33'h1_0000_0000);
    wt(2);
    chk("ports", lvl, 64'ha5c3_773c_1234_ff00);
    $display("t_lanes done");
  endtask : t_lanes
  task automatic t_am;
    pprot <= 3'h0;
    apb(0, CB, 0, 4'hf);
    chk("user refused", err, 1);
    am <= 1;
    wt(6);
    apb(0, CB, 0, 4'hf);
    chk("user csr", {err, rd}, 33'h0_0000_000a);
    pprot <= 3'h1;
    apb(0, CB, 0, 4'hf);
    chk("super refused", err, 1);
    am <= 0;
    cbs <= 14'h0090;
    wt(6);
    apb(0, 16'h0240, 0, 4'hf);
    chk("moved csr", err, 0);
    apb(0, CB, 0, 4'hf);
    chk("old csr", err, 1);
    cbs <= CB[15:2];
    wt(6);
    $display("t_am done");
  endtask : t_am
  task automatic t_test;
    apb(1, CB, 32'h0000_0001, 4'h1);
    wt(2);
    chk("test off", out_source | out_sink, 0);
    apb(0, CB, 0, 4'hf);
    chk("test csr", rd, 32'h0000_0003);
    apb(1, CB, 0, 4'h1);
    wt(2);
    chk("test exit", lvl, 64'ha5c3_773c_1234_ff00);
    apb(1, CB, 32'h0000_0002, 4'h1);
    wt(2);
    chk("fail cleared", fail_led, 0);
    apb(0, CB, 0, 4'hf);
    chk("fail csr", rd, 0);
    $display("t_test done");
  endtask : t_test
  // A second reset in mid-run lights the indicator again
  task automatic t_relit;
    presetn <= 0;
    wt(2);
    chk("relit", fail_led, 1);
    chk("reset off", out_source | out_sink, 0);
    presetn <= 1;
    wt(6);
    apb(0, CB, 0, 4'hf);
    chk("relit csr", rd, 32'h0000_0002);
    $display("t_relit done");
  endtask : t_relit
  initial begin
    wt(3);
    presetn <= 1;
    wt(6);
    t_reset();
    t_map();
    t_lanes();
    t_am();
    t_test();
    t_relit();
    results();
  end
  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #200us;
    fails++;
    results();
  end
endmodule : bopa_top_tb
bind bopa_top bopa_chk #(.PORTS(PORTS)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr, .am_nonpriv_strap,
  .sink_en_strap, .port_base_strap, .csr_base_strap, .out_source, .out_sink, .fail_led);
`default_nettype wire
